// File: design/vlm_limit_regs.sv
// Output voltage limit registers: mapping, warning status and undervoltage fault response
`timescale 1ns/1ps
`include "vlm_map.svh"

// Functional notes
// R1 - Limits 42h, 43h, 44h use word read/write
// R2 - Whole 16-bit value, relative or absolute format
// R3 - Overvoltage warning sets status and alerts host
// R4 - Undervoltage warning sets status and alerts host
// R5 - OV warning 103-116% steps 1%, round up
// R6 - UV warning 84-97% steps 1%, round down
// R7 - UV fault 60-95% steps 2.5%, round down
// R8 - Thresholds always relative to present target
// R9 - Target writes leave stored limits untouched
// R10 - Unsupported writes flag status, alert host
// R11 - UV fault runs configured shutdown and retry
// R12 - Writes act at once; reset from EEPROM
// R13 - Host keeps OV warning below OV fault
// R14 - Warning flags stay until host clears
module vlm_limit_regs import vlm_pkg::*; (
  // Clocks and resets
  input  logic        clock,
  input  logic        resetn,
  input  logic        link_clk,
  input  logic        link_resetn,
  // Bus transaction port, link domain
  input  logic        bus_req,
  input  logic        bus_write,
  input  logic [7:0]  bus_code,
  input  logic [15:0] bus_wdata,
  output logic        bus_busy,
  output logic        bus_done,
  output logic [15:0] bus_rdata,
  // Output voltage loop
  input  logic        vout_abs_mode,
  input  logic [15:0] vout_target,
  input  logic [15:0] vout_sense,
  // Nonvolatile restore
  input  logic        nvm_load,
  input  logic [15:0] nvm_ov_warn,
  input  logic [15:0] nvm_uv_warn,
  input  logic [15:0] nvm_uv_fault,
  // Status and host notification
  input  logic        clear_status,
  output logic [7:0]  status_vout,
  output logic        status_word_vout,
  output logic [7:0]  status_cml,
  output logic        host_alert,
  // Hardware threshold steps
  output logic [3:0]  ov_warn_step,
  output logic [3:0]  uv_warn_step,
  output logic [3:0]  uv_fault_step,
  // Undervoltage fault response
  input  logic [7:0]  uv_fault_resp,
  input  logic        pwm_tick,
  input  logic        hiccup_done,
  input  logic        start_ok,
  input  logic        restart_clear,
  output logic        uv_shutdown,
  output logic        uv_latched_off
);

  vlm_core_s        q;
  vlm_core_s        d;
  logic             req_tgl;
  logic             req_write;
  logic [7:0]       req_code;
  logic [15:0]      req_wdata;
  logic [15:0]      base;
  logic [27:0]      sense_pm;
  logic [2:0][15:0] cand;
  logic [2:0][27:0] val_pm;
  logic [2:0][27:0] thr_pm;
  logic [2:0][15:0] step_hi;
  logic [2:0][15:0] step_lo;
  logic [2:0][7:0]  cmd_code;

  // ****************************************
  // Step tables
  // ****************************************
  function automatic logic [4:0] step_num(input logic [1:0] lim);
    case (lim)
      2'h0:    step_num = `VLM_OVW_NUM;
      2'h1:    step_num = `VLM_UVW_NUM;
      default: step_num = `VLM_UVF_NUM;
    endcase
  endfunction : step_num

  function automatic logic [10:0] step_pm(input logic [1:0] lim, input logic [3:0] idx);
    case (lim)
      2'h0:    step_pm = 11'(`VLM_OVW_MIN + 11'(idx) * `VLM_OVW_STEP); // R5
      2'h1:    step_pm = 11'(`VLM_UVW_MIN + 11'(idx) * `VLM_UVW_STEP); // R6
      default: step_pm = 11'(`VLM_UVF_MIN + 11'(idx) * `VLM_UVF_STEP); // R7
    endcase
  endfunction : step_pm

  // ****************************************
  // Link side and crossing
  // ****************************************
  vlm_link u_link (
    .link_clk    (link_clk),
    .link_resetn (link_resetn),
    .bus_req     (bus_req),
    .bus_write   (bus_write),
    .bus_code    (bus_code),
    .bus_wdata   (bus_wdata),
    .bus_busy    (bus_busy),
    .bus_done    (bus_done),
    .bus_rdata   (bus_rdata),
    .ack_tgl     (q.ack_tgl),
    .core_rdata  (q.rdata),
    .req_tgl     (req_tgl),
    .req_write   (req_write),
    .req_code    (req_code),
    .req_wdata   (req_wdata)
  );

  // ****************************************
  // Value mapping and threshold products
  // ****************************************
  assign base     = vout_abs_mode ? vout_target : `VLM_REL_ONE; // R2
  assign sense_pm = 28'(vout_sense) * 28'(`VLM_PM_SCALE);
  assign cand[0]  = nvm_load ? nvm_ov_warn : req_wdata;
  assign cand[1]  = nvm_load ? nvm_uv_warn : req_wdata;
  assign cand[2]  = nvm_load ? nvm_uv_fault : req_wdata;
  assign cmd_code[0] = `VLM_CMD_OV_WARN;
  assign cmd_code[1] = `VLM_CMD_UV_WARN;
  assign cmd_code[2] = `VLM_CMD_UV_FAULT;

  for (genvar i = 0; i < 3; i++) begin : g_lim
    assign val_pm[i] = 28'(cand[i]) * 28'(`VLM_PM_SCALE); // R2
    // Percentage of the live target, whatever format the value came in
    assign thr_pm[i] = 28'(vout_target) * 28'(step_pm(2'(i), q.hw_idx[i])); // R8
    for (genvar k = 0; k < 16; k++) begin : g_step
      assign step_hi[i][k] = (5'(k) < step_num(2'(i))) &&
                             (28'(step_pm(2'(i), 4'(k))) * 28'(base) >= val_pm[i]);
      assign step_lo[i][k] = (5'(k) < step_num(2'(i))) &&
                             (28'(step_pm(2'(i), 4'(k))) * 28'(base) <= val_pm[i]);
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [2:0]      ok;
    logic [2:0][3:0] pick;
    logic [2:0]      cond;
    logic [4:0]      last;
    logic            new_req;
    logic [2:0]      dly_sel;
    logic [2:0]      retry_sel;
    logic [1:0]      resp_sel;
    ok        = '0;
    pick      = '0;
    cond      = '0;
    last      = '0;
    new_req   = 1'b0;
    dly_sel   = uv_fault_resp[`VLM_DLY_MSB:`VLM_DLY_LSB];
    retry_sel = uv_fault_resp[`VLM_RETRY_MSB:`VLM_RETRY_LSB];
    resp_sel  = uv_fault_resp[`VLM_RESP_MSB:`VLM_RESP_LSB];
    d         = q;
    d.req_s1  = req_tgl;
    d.req_s2  = q.req_s1;

    // Supported range check and rounding to a hardware step
    for (int i = 0; i < 3; i++) begin
      last  = 5'(step_num(2'(i)) - 5'h01);
      ok[i] = step_lo[i][0] && step_hi[i][last[3:0]]; // R10
      for (int k = 15; k >= 0; k--) begin
        if ((i == 0) && step_hi[i][k]) begin
          pick[i] = 4'(k); // R5
        end
      end
      for (int k = 0; k < 16; k++) begin
        if ((i != 0) && step_lo[i][k]) begin
          pick[i] = 4'(k); // R6 R7
        end
      end
    end

    // Host clear first so that a fresh event in the same cycle wins
    if (clear_status) begin
      d.stat_vout = '0; // R14
      d.stat_cml  = '0;
      d.vout_word = 1'b0;
    end

    // Restore from the nonvolatile copy; held bus requests wait until nvm_load drops
    if (nvm_load) begin
      d.loaded = 1'b1;
      for (int i = 0; i < 3; i++) begin
        d.lim[i] = cand[i]; // R12
        if (ok[i]) begin
          d.hw_idx[i] = pick[i]; // R12
        end else begin
          d.stat_cml[`VLM_CML_DATA_BIT] = 1'b1;
        end
      end
    end else begin
      new_req = (q.req_s2 != q.req_seen);
    end

    // Word read and word write of the three limits
    if (new_req) begin
      d.req_seen = q.req_s2;
      d.ack_tgl  = ~q.ack_tgl;
      d.rdata    = `VLM_RDATA_RESET;
      if ((req_code != cmd_code[0]) && (req_code != cmd_code[1]) &&
          (req_code != cmd_code[2])) begin
        d.stat_cml[`VLM_CML_CMD_BIT] = 1'b1;
      end
      for (int i = 0; i < 3; i++) begin
        if (req_code == cmd_code[i]) begin
          if (!req_write) begin
            d.rdata = q.lim[i]; // R1
          end else if (ok[i]) begin
            d.lim[i]    = req_wdata; // R1 R9
            d.hw_idx[i] = pick[i]; // R12
          end else begin
            d.stat_cml[`VLM_CML_DATA_BIT] = 1'b1; // R10
          end
        end
      end
    end

    // Threshold comparisons against the live target
    cond[0] = q.loaded && (sense_pm > thr_pm[0]);
    cond[1] = q.loaded && (sense_pm < thr_pm[1]);
    cond[2] = q.loaded && (sense_pm < thr_pm[2]);
    if (cond[0]) begin
      d.stat_vout[`VLM_SV_OVW_BIT] = 1'b1; // R3
      d.vout_word                  = 1'b1; // R3
    end
    if (cond[1]) begin
      d.stat_vout[`VLM_SV_UVW_BIT] = 1'b1; // R4
      d.vout_word                  = 1'b1; // R4
    end

    // Undervoltage fault response
    if (start_ok) begin
      d.retry_cnt = '0;
    end
    case (q.uv_st)
      UV_MON: begin
        if (cond[2]) begin
          d.stat_vout[`VLM_SV_UVF_BIT] = 1'b1;
          d.vout_word                  = 1'b1;
          if (resp_sel == `VLM_RESP_DELAYED) begin
            d.uv_st = UV_DELAY; // R11
            if (dly_sel <= 3'h1) begin
              d.dly_cnt = `VLM_DLY_SHORT;
            end else if (dly_sel <= 3'h4) begin
              d.dly_cnt = `VLM_DLY_MID;
            end else begin
              d.dly_cnt = `VLM_DLY_LONG;
            end
          end else if (resp_sel == `VLM_RESP_NOW) begin
            d.uv_st    = UV_OFF; // R11
            d.shutdown = 1'b1;
          end
        end
      end
      UV_DELAY: begin
        if (pwm_tick) begin
          if (q.dly_cnt <= 3'h1) begin
            d.uv_st    = UV_OFF; // R11
            d.shutdown = 1'b1;
          end else begin
            d.dly_cnt = 3'(q.dly_cnt - 3'h1);
          end
        end
      end
      UV_OFF: begin
        if (hiccup_done) begin
          if ((retry_sel == `VLM_RETRY_NEVER) ||
              ((retry_sel != `VLM_RETRY_FOREVER) && (q.retry_cnt >= retry_sel))) begin
            d.uv_st       = UV_LATCHED; // R11
            d.latched_off = 1'b1;
          end else begin
            d.uv_st     = UV_MON; // R11
            d.shutdown  = 1'b0;
            if (retry_sel != `VLM_RETRY_FOREVER) begin
              d.retry_cnt = 3'(q.retry_cnt + 3'h1);
            end
          end
        end
      end
      UV_LATCHED: begin
        if (restart_clear) begin
          d.uv_st       = UV_MON;
          d.shutdown    = 1'b0;
          d.latched_off = 1'b0;
          d.retry_cnt   = '0;
        end
      end
      default: begin
        d.uv_st = UV_MON;
      end
    endcase

    // Alert follows any pending status
    d.alert = d.vout_word || (|d.stat_vout) || (|d.stat_cml); // R3 R4 R10
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q        <= '0;
      q.lim    <= {3{`VLM_LIM_RESET}};
      q.hw_idx <= {3{`VLM_IDX_RESET}};
      q.uv_st  <= UV_MON;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign status_vout      = q.stat_vout;
  assign status_word_vout = q.vout_word;
  assign status_cml       = q.stat_cml;
  assign host_alert       = q.alert;
  assign ov_warn_step     = q.hw_idx[0];
  assign uv_warn_step     = q.hw_idx[1];
  assign uv_fault_step    = q.hw_idx[2];
  assign uv_shutdown      = q.shutdown;
  assign uv_latched_off   = q.latched_off;

endmodule : vlm_limit_regs

// File: design/vlm_link.sv
// Link-clock end of the bus transaction port with a toggle handshake to the core
`timescale 1ns/1ps
`include "vlm_map.svh"

module vlm_link import vlm_pkg::*; (
  // Link clock and reset
  input  logic        link_clk,
  input  logic        link_resetn,
  // Transaction port
  input  logic        bus_req,
  input  logic        bus_write,
  input  logic [7:0]  bus_code,
  input  logic [15:0] bus_wdata,
  output logic        bus_busy,
  output logic        bus_done,
  output logic [15:0] bus_rdata,
  // Core side
  input  logic        ack_tgl,
  input  logic [15:0] core_rdata,
  output logic        req_tgl,
  output logic        req_write,
  output logic [7:0]  req_code,
  output logic [15:0] req_wdata
);

  vlm_link_s q;
  vlm_link_s d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d        = q;
    d.done   = 1'b0;
    d.ack_s1 = ack_tgl;
    d.ack_s2 = q.ack_s1;
    // Request words stay frozen until the core answers
    if (!q.busy && bus_req) begin
      d.busy    = 1'b1;
      d.write   = bus_write;
      d.code    = bus_code;
      d.wdata   = bus_wdata;
      d.req_tgl = ~q.req_tgl;
    end
    // Read data is stable in the core once its toggle has crossed
    if (q.busy && (q.ack_s2 != q.ack_seen)) begin
      d.ack_seen = q.ack_s2;
      d.busy     = 1'b0;
      d.done     = 1'b1;
      d.rdata    = core_rdata;
    end
  end

  always_ff @(posedge link_clk or negedge link_resetn) begin
    if (!link_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus_busy  = q.busy;
  assign bus_done  = q.done;
  assign bus_rdata = q.rdata;
  assign req_tgl   = q.req_tgl;
  assign req_write = q.write;
  assign req_code  = q.code;
  assign req_wdata = q.wdata;

endmodule : vlm_link

// File: design/vlm_map.svh
// Command codes, field positions, reset values and step tables of the limit monitor
`ifndef VLM_MAP_SVH
`define VLM_MAP_SVH

// ****************************************
// Command codes
// ****************************************
`define VLM_CMD_OV_WARN   8'h42
`define VLM_CMD_UV_WARN   8'h43
`define VLM_CMD_UV_FAULT  8'h44

// ****************************************
// Reset values
// ****************************************
`define VLM_LIM_RESET     16'h0000
`define VLM_IDX_RESET     4'h0
`define VLM_RDATA_RESET   16'h0000

// ****************************************
// Value scaling: per-mille of the target, relative 1.0 code
// ****************************************
`define VLM_PM_SCALE      11'h3e8
`define VLM_REL_ONE       16'h0200

// ****************************************
// Hardware step tables in per-mille
// ****************************************
`define VLM_OVW_MIN       11'h406
`define VLM_OVW_STEP      11'h00a
`define VLM_OVW_NUM       5'h0e
`define VLM_UVW_MIN       11'h348
`define VLM_UVW_STEP      11'h00a
`define VLM_UVW_NUM       5'h0e
`define VLM_UVF_MIN       11'h258
`define VLM_UVF_STEP      11'h019
`define VLM_UVF_NUM       5'h0f

// ****************************************
// Status bit positions
// ****************************************
`define VLM_SV_OVW_BIT    6
`define VLM_SV_UVW_BIT    5
`define VLM_SV_UVF_BIT    4
`define VLM_CML_CMD_BIT   7
`define VLM_CML_DATA_BIT  6

// ****************************************
// Fault response fields and delays in PWM ticks
// ****************************************
`define VLM_RESP_MSB      7
`define VLM_RESP_LSB      6
`define VLM_RETRY_MSB     5
`define VLM_RETRY_LSB     3
`define VLM_DLY_MSB       2
`define VLM_DLY_LSB       0
`define VLM_RESP_IGNORE   2'h0
`define VLM_RESP_DELAYED  2'h1
`define VLM_RESP_NOW      2'h2
`define VLM_RETRY_NEVER   3'h0
`define VLM_RETRY_FOREVER 3'h7
`define VLM_DLY_SHORT     3'h1
`define VLM_DLY_MID       3'h3
`define VLM_DLY_LONG      3'h7

`endif

// File: design/vlm_pkg.sv
// Types shared by the limit monitor modules
package vlm_pkg;

  // ****************************************
  // Undervoltage fault response states
  // ****************************************
  typedef enum logic [1:0] {
    UV_MON,
    UV_DELAY,
    UV_OFF,
    UV_LATCHED
  } vlm_uv_e;

  // ****************************************
  // Core domain state
  // ****************************************
  typedef struct packed {
    logic             req_s1;
    logic             req_s2;
    logic             req_seen;
    logic             ack_tgl;
    logic [15:0]      rdata;
    logic [2:0][15:0] lim;
    logic [2:0][3:0]  hw_idx;
    logic             loaded;
    logic [7:0]       stat_vout;
    logic             vout_word;
    logic [7:0]       stat_cml;
    logic             alert;
    vlm_uv_e          uv_st;
    logic [2:0]       dly_cnt;
    logic [2:0]       retry_cnt;
    logic             shutdown;
    logic             latched_off;
  } vlm_core_s;

  // ****************************************
  // Link domain state
  // ****************************************
  typedef struct packed {
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_seen;
    logic        req_tgl;
    logic        busy;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
  } vlm_link_s;

endpackage : vlm_pkg

// File: verification/vlm_host_model.sv
// Bus host model issuing whole-word reads and writes on the link clock
`timescale 1ns/1ps

module vlm_host_model (
  // Link clock and reset
  input  logic        link_clk,
  input  logic        link_resetn,
  // Transaction port
  output logic        bus_req,
  output logic        bus_write,
  output logic [7:0]  bus_code,
  output logic [15:0] bus_wdata,
  input  logic        bus_busy,
  input  logic        bus_done,
  input  logic [15:0] bus_rdata
);
  initial begin
    bus_req   = 1'b0;
    bus_write = 1'b0;
    bus_code  = 8'h00;
    bus_wdata = 16'h0000;
  end

  // Released fields are scrambled so stale values never pass for live ones
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q);
    q = 16'hxxxx;
    @(posedge link_clk);
    #1;
    bus_req   = 1'b1;
    bus_write = w;
    bus_code  = c;
    bus_wdata = d;
    // Hold the request until the port has taken it
    do begin
      @(posedge link_clk);
      #1;
    end while (bus_busy !== 1'b1);
    bus_req   = 1'b0;
    bus_write = ~w;
    bus_code  = ~c;
    bus_wdata = ~d;
    repeat (40) begin
      @(posedge link_clk);
      #1;
      if (bus_done === 1'b1) begin
        q = bus_rdata;
        break;
      end
    end
  endtask : xfer
endmodule : vlm_host_model

// File: verification/vlm_limit_regs_sva.sv
// Assertion checker for the output voltage limit registers
`timescale 1ns/1ps

module vlm_limit_regs_sva import vlm_pkg::*; (
  // Clocks and resets
  input logic        clock,
  input logic        resetn,
  input logic        link_clk,
  input logic        link_resetn,
  // Bus port
  input logic        bus_busy,
  input logic        bus_done,
  // Loop, restore and status
  input logic [15:0] vout_target,
  input logic [15:0] vout_sense,
  input logic        nvm_load,
  input logic        clear_status,
  input logic [7:0]  status_vout,
  input logic        status_word_vout,
  input logic [7:0]  status_cml,
  input logic        host_alert,
  input logic [3:0]  ov_warn_step,
  input logic [3:0]  uv_warn_step,
  input logic [3:0]  uv_fault_step,
  input logic [7:0]  uv_fault_resp,
  input logic        uv_shutdown,
  input logic        uv_latched_off
);
  // ****************************************
  // Comparisons start after the first restore
  // ****************************************
  logic loaded_q;
  logic loaded_d;

  always_comb loaded_d = loaded_q | nvm_load;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) loaded_q <= 1'b0;
    else loaded_q <= loaded_d;
  end

  a_done_single: assert property (@(posedge link_clk) disable iff (!link_resetn)
    bus_done |=> !bus_done) else $error("done pulse longer than one cycle");
  a_busy_ends: assert property (@(posedge link_clk) disable iff (!link_resetn)
    $rose(bus_busy) |-> ##[1:20] bus_done) else $error("transfer never completed");
  a_done_unbusy: assert property (@(posedge link_clk) disable iff (!link_resetn)
    bus_done |-> !bus_busy) else $error("busy still high at done");
  a_alert_pending: assert property (@(posedge clock) disable iff (!resetn)
    (|status_vout) || (|status_cml) |-> host_alert) else $error("alert missing");
  a_word_follows: assert property (@(posedge clock) disable iff (!resetn)
    status_vout[6] || status_vout[5] |-> status_word_vout) else $error("summary bit missing");
  a_ov_warn_set: assert property (@(posedge clock) disable iff (!resetn)
    loaded_q && vout_sense * 32'd1000 > vout_target * (32'd1030 + 32'd10 * ov_warn_step)
    |=> status_vout[6]) else $error("ov warning not flagged");
  a_uv_warn_set: assert property (@(posedge clock) disable iff (!resetn)
    loaded_q && vout_sense * 32'd1000 < vout_target * (32'd840 + 32'd10 * uv_warn_step)
    |=> status_vout[5]) else $error("uv warning not flagged");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!resetn)
    !clear_status |=> (status_vout[6:5] & $past(status_vout[6:5])) == $past(status_vout[6:5]))
    else $error("warning flag dropped");
  a_uv_now_off: assert property (@(posedge clock) disable iff (!resetn)
    loaded_q && uv_fault_resp[7:6] == 2'h2 && !uv_shutdown && !uv_latched_off &&
    vout_sense * 32'd1000 < vout_target * (32'd600 + 32'd25 * uv_fault_step)
    |=> uv_shutdown) else $error("immediate shutdown missing");
endmodule : vlm_limit_regs_sva

bind vlm_limit_regs vlm_limit_regs_sva u_sva (
  .clock(clock), .resetn(resetn), .link_clk(link_clk), .link_resetn(link_resetn),
  .bus_busy(bus_busy), .bus_done(bus_done), .vout_target(vout_target),
  .vout_sense(vout_sense), .nvm_load(nvm_load), .clear_status(clear_status),
  .status_vout(status_vout), .status_word_vout(status_word_vout), .status_cml(status_cml),
  .host_alert(host_alert), .ov_warn_step(ov_warn_step), .uv_warn_step(uv_warn_step),
  .uv_fault_step(uv_fault_step), .uv_fault_resp(uv_fault_resp), .uv_shutdown(uv_shutdown),
  .uv_latched_off(uv_latched_off)
);

// File: verification/vlm_limit_regs_test.sv
// Self-checking bench for the output voltage limit registers
`timescale 1ns/1ps
`include "vlm_map.svh"

module vlm_limit_regs_test import vlm_pkg::*;;
  logic        clock = 1'b0, link_clk = 1'b0, resetn = 1'b0, link_resetn = 1'b0;
  logic        bus_req, bus_write, bus_busy, bus_done, status_word_vout, host_alert;
  logic        uv_shutdown, uv_latched_off, vout_abs_mode = 1'b1;
  logic        pwm_tick = 1'b0, start_ok = 1'b0;
  logic        nvm_load = 1'b0, clear_status = 1'b0, hiccup_done = 1'b0, restart_clear = 1'b0;
  logic [7:0]  bus_code, status_vout, status_cml, uv_fault_resp = 8'h00;
  logic [15:0] bus_wdata, bus_rdata, rd, vout_target = 16'h03e8, vout_sense = 16'h03e8;
  logic [15:0] nvm_ov_warn = 16'h044c, nvm_uv_warn = 16'h0384, nvm_uv_fault = 16'h02bc;
  logic [3:0]  ov_warn_step, uv_warn_step, uv_fault_step;
  int          error_cnt = 0, total_checks = 0, cyc = 0;
  logic [7:0]  t_code [7] = '{8'h42, 8'h42, 8'h42, 8'h43, 8'h43, 8'h44, 8'h44};
  logic [15:0] t_val  [7] = '{16'h0406, 16'h040b, 16'h0488, 16'h03c9, 16'h034d, 16'h0264,
                              16'h03b6};
  logic [3:0]  t_step [7] = '{4'h0, 4'h1, 4'hd, 4'hc, 4'h0, 4'h0, 4'he};

  always #5 clock = ~clock;
  initial begin
    #2.3;
    forever #15 link_clk = ~link_clk;
  end

  vlm_limit_regs u_dut (
    .clock(clock), .resetn(resetn), .link_clk(link_clk), .link_resetn(link_resetn),
    .bus_req(bus_req), .bus_write(bus_write), .bus_code(bus_code), .bus_wdata(bus_wdata),
    .bus_busy(bus_busy), .bus_done(bus_done), .bus_rdata(bus_rdata),
    .vout_abs_mode(vout_abs_mode), .vout_target(vout_target), .vout_sense(vout_sense),
    .nvm_load(nvm_load), .nvm_ov_warn(nvm_ov_warn), .nvm_uv_warn(nvm_uv_warn),
    .nvm_uv_fault(nvm_uv_fault), .clear_status(clear_status), .status_vout(status_vout),
    .status_word_vout(status_word_vout), .status_cml(status_cml), .host_alert(host_alert),
    .ov_warn_step(ov_warn_step), .uv_warn_step(uv_warn_step), .uv_fault_step(uv_fault_step),
    .uv_fault_resp(uv_fault_resp), .pwm_tick(pwm_tick), .hiccup_done(hiccup_done),
    .start_ok(start_ok), .restart_clear(restart_clear), .uv_shutdown(uv_shutdown),
    .uv_latched_off(uv_latched_off)
  );

  vlm_host_model u_host (
    .link_clk(link_clk), .link_resetn(link_resetn), .bus_req(bus_req),
    .bus_write(bus_write), .bus_code(bus_code), .bus_wdata(bus_wdata),
    .bus_busy(bus_busy), .bus_done(bus_done), .bus_rdata(bus_rdata)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b1, c, d, rd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
    u_host.xfer(1'b0, c, 16'h0000, rd);
    check("read word", rd, exp);
  endtask : rd_chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  function automatic logic [3:0] step_of(input logic [7:0] c);
    case (c)
      `VLM_CMD_OV_WARN: return ov_warn_step;
      `VLM_CMD_UV_WARN: return uv_warn_step;
      default: return uv_fault_step;
    endcase
  endfunction : step_of

  task automatic finish_test;
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    tick(8);
    resetn = 1'b1;
    @(posedge link_clk);
    #1;
    link_resetn = 1'b1;
    tick(1);
    nvm_load = 1'b1;
    tick(1);
    nvm_load = 1'b0;
    tick(2);
    check("ov step", ov_warn_step, 4'h7);
    check("uv step", uv_warn_step, 4'h6);
    check("uvf step", uv_fault_step, 4'h4);
    rd_chk(`VLM_CMD_OV_WARN, 16'h044c);
    rd_chk(`VLM_CMD_UV_WARN, 16'h0384);
    rd_chk(`VLM_CMD_UV_FAULT, 16'h02bc);
    foreach (t_code[i]) begin
      wr(t_code[i], t_val[i]);
      rd_chk(t_code[i], t_val[i]);
      check("step", step_of(t_code[i]), t_step[i]);
    end
    wr(`VLM_CMD_OV_WARN, 16'h0489);
    rd_chk(`VLM_CMD_OV_WARN, 16'h0488);
    check("ov step kept", ov_warn_step, 4'hd);
    check("data flag", status_cml[`VLM_CML_DATA_BIT], 1'b1);
    check("alert", host_alert, 1'b1);
    rd_chk(8'h45, 16'h0000);
    check("cmd flag", status_cml[`VLM_CML_CMD_BIT], 1'b1);
    wr(`VLM_CMD_OV_WARN, 16'h044c);
    tick(1);
    vout_target = 16'h07d0;
    vout_sense = 16'h07d0;
    clear_status = 1'b1;
    tick(1);
    clear_status = 1'b0;
    tick(2);
    check("alert cleared", host_alert, 1'b0);
    rd_chk(`VLM_CMD_OV_WARN, 16'h044c);
    vout_sense = 16'h0899;
    tick(2);
    check("ov flag", status_vout[`VLM_SV_OVW_BIT], 1'b1);
    check("vout word", status_word_vout, 1'b1);
    vout_sense = 16'h07d0;
    tick(3);
    check("ov flag held", status_vout[`VLM_SV_OVW_BIT], 1'b1);
    clear_status = 1'b1;
    tick(1);
    clear_status = 1'b0;
    tick(1);
    check("vout flags", status_vout, 8'h00);
    uv_fault_resp = 8'h80;
    vout_sense = 16'h068f;
    tick(3);
    check("uv flag", status_vout[`VLM_SV_UVW_BIT], 1'b1);
    check("uvf flag", status_vout[`VLM_SV_UVF_BIT], 1'b1);
    check("shutdown", uv_shutdown, 1'b1);
    hiccup_done = 1'b1;
    tick(1);
    hiccup_done = 1'b0;
    tick(2);
    check("latched", uv_latched_off, 1'b1);
    vout_sense = 16'h07d0;
    restart_clear = 1'b1;
    tick(1);
    restart_clear = 1'b0;
    tick(2);
    check("unlatched", uv_latched_off, 1'b0);
    // Delayed shutdown after three PWM ticks, one retry, start clears the count
    uv_fault_resp = 8'h4b;
    repeat (2) begin
      vout_sense = 16'h068f;
      tick(1);
      repeat (3) begin
        check("no early off", uv_shutdown, 1'b0);
        pwm_tick = 1'b1;
        tick(1);
        pwm_tick = 1'b0;
        tick(1);
      end
      check("delayed off", uv_shutdown, 1'b1);
      vout_sense = 16'h07d0;
      hiccup_done = 1'b1;
      tick(1);
      hiccup_done = 1'b0;
      start_ok = 1'b1;
      tick(1);
      start_ok = 1'b0;
      tick(1);
      check("retried", uv_shutdown, 1'b0);
      check("not latched", uv_latched_off, 1'b0);
    end
    // Relative format: 0.9375 of nominal rounds down to 93 percent
    vout_abs_mode = 1'b0;
    wr(`VLM_CMD_UV_WARN, 16'h01e0);
    rd_chk(`VLM_CMD_UV_WARN, 16'h01e0);
    check("rel uv step", uv_warn_step, 4'h9);
    finish_test();
  end
endmodule : vlm_limit_regs_test
